//--- src/itc_pkg.sv
// Summary of operation
// [RULE_01] Capture filter and edge bits: inert storage.
// [RULE_02] Control B bit 5 reads zero, ignores writes.
// [RULE_03] Wave mode joins control B and A bits.
// [RULE_04] Modes 0x0 to 0x7 decoded as listed.
// [RULE_05] Modes 0x8 to 0xF decoded as listed.
// [RULE_06] Tick select: stop, divide 1 to 1024.
// [RULE_07] Software uses no external pin clock.
// [RULE_08] Force write matches only in non-PWM modes.
// [RULE_09] Forced match: no interrupt, no counter clear.
// [RULE_10] Forced match follows output mode, drives nothing.
// [RULE_11] Force bits are strobes reading zero.
// [RULE_12] Control C low bits reserved, read zero.
// [RULE_13] Counter readable and writable as byte pair.
// [RULE_14] Word access goes through temporary high byte.
// [RULE_15] One temporary byte shared by all registers.
// [RULE_16] Counter write blocks compare on next tick.
// [RULE_17] Software avoids changing a running counter.
// [RULE_18] Compare registers matched against counter continuously.
// [RULE_19] Output mode zero normal, others reserved.
// [RULE_20] High write parks; low write commits; low read latches.
// [RULE_21] Counter steps per tick, frozen when stopped.
package itc_pkg;
   // Register indices; the byte address is four times the index.
   localparam logic [9:0] IDX_CTRL_A = 10'h120;
   localparam logic [9:0] IDX_CTRL_B = 10'h121;
   localparam logic [9:0] IDX_CTRL_C = 10'h122;
   localparam logic [9:0] IDX_CNT_L  = 10'h124;
   localparam logic [9:0] IDX_CNT_H  = 10'h125;
   localparam logic [9:0] IDX_CAP_L  = 10'h126;
   localparam logic [9:0] IDX_CAP_H  = 10'h127;
   localparam logic [9:0] IDX_CMP_L  = 10'h128;
   localparam logic [9:0] IDX_CMP_H  = 10'h129;
   // Control B field positions and writable mask.
   localparam int         B_RES_BIT  = 5;
   localparam logic [7:0] B_WR_MASK  = 8'hdf;
   // Control C force strobe positions.
   localparam int         C_FORCE_A  = 7;
   localparam int         C_FORCE_B  = 6;
   localparam int         C_FORCE_C  = 5;
   // Reset values.
   localparam logic [7:0]  RST_BYTE  = 8'h00;
   localparam logic [15:0] RST_WORD  = 16'h0000;
   // Waveform modes.
   localparam logic [3:0] M_NORMAL   = 4'h0;
   localparam logic [3:0] M_PC8      = 4'h1;
   localparam logic [3:0] M_PC9      = 4'h2;
   localparam logic [3:0] M_PC10     = 4'h3;
   localparam logic [3:0] M_CTC_A    = 4'h4;
   localparam logic [3:0] M_FAST8    = 4'h5;
   localparam logic [3:0] M_FAST9    = 4'h6;
   localparam logic [3:0] M_FAST10   = 4'h7;
   localparam logic [3:0] M_PFC_CAP  = 4'h8;
   localparam logic [3:0] M_PFC_A    = 4'h9;
   localparam logic [3:0] M_PC_CAP   = 4'ha;
   localparam logic [3:0] M_PC_A     = 4'hb;
   localparam logic [3:0] M_CTC_A2   = 4'hc;
   localparam logic [3:0] M_RSVD     = 4'hd;
   localparam logic [3:0] M_FAST_CAP = 4'he;
   localparam logic [3:0] M_FAST_A   = 4'hf;
   // Tick selections.
   localparam logic [2:0] T_STOP     = 3'h0;
   localparam logic [2:0] T_DIV1     = 3'h1;
   localparam logic [2:0] T_DIV8     = 3'h2;
   localparam logic [2:0] T_DIV64    = 3'h3;
   localparam logic [2:0] T_DIV256   = 3'h4;
   localparam logic [2:0] T_DIV1024  = 3'h5;
   // Prescaler terminal masks.
   localparam logic [9:0] P_MASK8    = 10'h007;
   localparam logic [9:0] P_MASK64   = 10'h03f;
   localparam logic [9:0] P_MASK256  = 10'h0ff;
   localparam logic [9:0] P_MASK1024 = 10'h3ff;
   // Fixed top values.
   localparam logic [15:0] TOP8      = 16'h00ff;
   localparam logic [15:0] TOP9      = 16'h01ff;
   localparam logic [15:0] TOP10     = 16'h03ff;
   localparam logic [15:0] TOP_MAX   = 16'hffff;
   localparam logic [15:0] ONE16     = 16'h0001;
endpackage

//--- src/itc_timer.sv
`timescale 1ns/1ps
module itc_timer
   import itc_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [11:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic      [15:0] countValue,
   output logic      [2:0]  matchEvent,
   output logic      [2:0]  forcedMatch
);

   // Non-PWM modes are the only ones in which a force strobe acts.
   function automatic logic isPwm(input logic [3:0] m);
      isPwm = !(m == M_NORMAL || m == M_CTC_A || m == M_CTC_A2 ||
                m == M_RSVD);
   endfunction

   // Dual-slope modes count up to top and back down to zero.
   function automatic logic isDual(input logic [3:0] m);
      isDual = (m == M_PC8 || m == M_PC9 || m == M_PC10 ||
                m == M_PFC_CAP || m == M_PFC_A || m == M_PC_CAP ||
                m == M_PC_A);
   endfunction

   // Top value per mode; reserved mode runs like normal counting.
   function automatic logic [15:0] topOf(input logic [3:0]  m,
                                         input logic [15:0] cmpTop,
                                         input logic [15:0] capTop);
      case (m)
         M_PC8, M_FAST8: begin
            topOf = TOP8;
         end
         M_PC9, M_FAST9: begin
            topOf = TOP9;
         end
         M_PC10, M_FAST10: begin
            topOf = TOP10;
         end
         M_CTC_A, M_PFC_A, M_PC_A, M_CTC_A2, M_FAST_A: begin
            topOf = cmpTop;
         end
         M_PFC_CAP, M_PC_CAP, M_FAST_CAP: begin
            topOf = capTop;
         end
         default: begin
            topOf = TOP_MAX;
         end
      endcase
   endfunction

   // Prescaler tap for the selected division; reserved codes never tick.
   function automatic logic tickOf(input logic [2:0] s,
                                   input logic [9:0] p);
      case (s)
         T_DIV1: begin
            tickOf = 1'b1;
         end
         T_DIV8: begin
            tickOf = (p & P_MASK8) == P_MASK8;
         end
         T_DIV64: begin
            tickOf = (p & P_MASK64) == P_MASK64;
         end
         T_DIV256: begin
            tickOf = (p & P_MASK256) == P_MASK256;
         end
         T_DIV1024: begin
            tickOf = (p & P_MASK1024) == P_MASK1024;
         end
         default: begin
            tickOf = 1'b0;
         end
      endcase
   endfunction

   logic [7:0]  ctrlA;
   logic [7:0]  ctrlB;
   logic [7:0]  temp;
   logic [15:0] count;
   logic [15:0] cmpVal [3];
   logic [9:0]  prescale;
   logic        countDown;
   logic        matchBlock;
   logic [2:0]  hit;
   logic [7:0]  rdByte;

   // Bus decode: every access is taken on the edge that raises ack.
   wire        wbReq    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire        wrEn     = wbReq & wb_we_i & wb_sel_i[0];
   wire        rdEn     = wbReq & ~wb_we_i;
   wire [9:0]  idx      = wb_adr_i[11:2];
   wire [7:0]  wrByte   = wb_dat_i[7:0];
   // The capture register is never loaded, so it always holds reset.
   wire [15:0] capVal   = RST_WORD;

   // Control A low bits supply the lower half of the mode.
   wire [3:0]  waveMode = {ctrlB[4:3], ctrlA[1:0]};  // [RULE_03]
   wire [2:0]  tickSel  = ctrlB[2:0];
   wire        tick     = tickOf(tickSel, prescale);  // [RULE_06]
   wire [15:0] top      = topOf(waveMode, cmpVal[0],  // [RULE_04] [RULE_05]
                                capVal);
   wire        dual     = isDual(waveMode);
   wire        cntWrite = wrEn & (idx == IDX_CNT_L);  // [RULE_13]
   wire        forceWr  = wrEn & (idx == IDX_CTRL_C) &  // [RULE_08]
                          ~isPwm(waveMode);
   wire        atTop    = count >= top;
   wire        atZero   = count == RST_WORD;
   wire [15:0] stepUp   = count + ONE16;
   wire [15:0] stepDn   = count - ONE16;

   // Dual slope turns at top and zero; a zero top holds the count.
   wire [15:0] dualNext = countDown ? (atZero ? stepUp : stepDn) :
                          (atTop ? (top == RST_WORD ? count : stepDn) :
                           stepUp);
   wire        dualDir  = countDown ? ~atZero :
                          (atTop ? (top != RST_WORD) : 1'b0);
   // Single slope wraps to zero once top is reached or passed.
   wire [15:0] slopeNext = atTop ? RST_WORD : stepUp;

   // A counter write wins over a tick landing in the same cycle.
   wire [15:0] next_count = cntWrite ? {temp, wrByte} :  // [RULE_14] [RULE_20]
                            !tick ? count :  // [RULE_21]
                            dual ? dualNext : slopeNext;  // [RULE_21]
   wire        next_countDown = cntWrite ? 1'b0 :
                                !tick ? countDown :
                                dual ? dualDir : 1'b0;
   // The block is set by a write and outlives it by exactly one tick.
   wire        next_matchBlock = cntWrite ? 1'b1 :  // [RULE_16]
                                 tick ? 1'b0 : matchBlock;

   // High writes of the counter and compare registers park in the one shared byte.
   wire        hiWrite  = wrEn & (idx == IDX_CNT_H ||
                                  idx == IDX_CMP_H ||
                                  idx == IDX_CMP_H + 10'h002 ||
                                  idx == IDX_CMP_H + 10'h004);  // [RULE_15]
   wire        loRead   = rdEn & (idx == IDX_CNT_L || idx == IDX_CAP_L ||
                                  idx == IDX_CMP_L ||
                                  idx == IDX_CMP_L + 10'h002 ||
                                  idx == IDX_CMP_L + 10'h004);
   wire        hiRead   = idx == IDX_CNT_H || idx == IDX_CAP_H ||
                          idx == IDX_CMP_H ||
                          idx == IDX_CMP_H + 10'h002 ||
                          idx == IDX_CMP_H + 10'h004;
   wire [7:0]  loHigh   = (idx == IDX_CNT_L) ? count[15:8] :
                          (idx == IDX_CAP_L) ? capVal[15:8] :
                          (idx == IDX_CMP_L) ? cmpVal[0][15:8] :
                          (idx == IDX_CMP_L + 10'h002) ? cmpVal[1][15:8] :
                          cmpVal[2][15:8];
   wire [7:0]  next_temp = hiWrite ? wrByte :  // [RULE_20]
                           loRead ? loHigh : temp;  // [RULE_14]

   // Read selection; unmapped indices and all reserved bits read zero.
   always_comb begin
      rdByte = RST_BYTE;
      if (hiRead) begin
         rdByte = temp;  // [RULE_20]
      end else if (idx == IDX_CTRL_A) begin
         rdByte = ctrlA;
      end else if (idx == IDX_CTRL_B) begin
         rdByte = ctrlB & B_WR_MASK;  // [RULE_02]
      end else if (idx == IDX_CTRL_C) begin
         rdByte = RST_BYTE;  // [RULE_11] [RULE_12]
      end else if (idx == IDX_CNT_L) begin
         rdByte = count[7:0];
      end else if (idx == IDX_CMP_L) begin
         rdByte = cmpVal[0][7:0];
      end else if (idx == IDX_CMP_L + 10'h002) begin
         rdByte = cmpVal[1][7:0];
      end else if (idx == IDX_CMP_L + 10'h004) begin
         rdByte = cmpVal[2][7:0];
      end
   end

   // Bus answer: ack for exactly one cycle, data held until next read.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wbReq;
         if (rdEn) begin
            wb_dat_o <= {24'h00_0000, rdByte};
         end
      end
   end

   // Control storage; the capture bits are kept but steer nothing.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrlA <= RST_BYTE;
         ctrlB <= RST_BYTE;
      end else begin
         if (wrEn && idx == IDX_CTRL_A) begin
            ctrlA <= wrByte;  // [RULE_19]
         end
         if (wrEn && idx == IDX_CTRL_B) begin
            ctrlB <= wrByte & B_WR_MASK;  // [RULE_01] [RULE_02]
         end
      end
   end

   // Prescaler is held clear while stopped so each start is aligned.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prescale <= 10'h000;
      end else if (tickSel == T_STOP) begin
         prescale <= 10'h000;
      end else begin
         prescale <= prescale + 10'h001;
      end
   end

   // Counter, direction, compare block and shared high byte.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         count      <= RST_WORD;
         countDown  <= 1'b0;
         matchBlock <= 1'b0;
         temp       <= RST_BYTE;
      end else begin
         count      <= next_count;
         countDown  <= next_countDown;
         matchBlock <= next_matchBlock;
         temp       <= next_temp;
      end
   end

   // One compare channel per generate pass; low write commits the word.
   for (genvar i = 0; i < 3; i++) begin : g_cmp
      localparam logic [9:0] LO = IDX_CMP_L + 10'(2 * i);
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            cmpVal[i] <= RST_WORD;
         end else if (wrEn && idx == LO) begin
            cmpVal[i] <= {temp, wrByte};  // [RULE_14] [RULE_20]
         end
      end
      // Match is checked on each tick unless a counter write blocks it.
      assign hit[i] = tick & ~matchBlock &  // [RULE_18] [RULE_16]
                      (count == cmpVal[i]);
   end

   // Events: real matches, and forced strobes that raise no match event.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         matchEvent  <= 3'h0;
         forcedMatch <= 3'h0;
         countValue  <= RST_WORD;
      end else begin
         matchEvent  <= hit;  // [RULE_09]
         forcedMatch <= forceWr ?  // [RULE_08] [RULE_10]
                        {wrByte[C_FORCE_C], wrByte[C_FORCE_B],
                         wrByte[C_FORCE_A]} : 3'h0;
         countValue  <= next_count;
      end
   end

   // Checker copy of the compare block: a counter write arms it and the
   // next tick spends it, so the block is held against its own model.
   logic chkArmed;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         chkArmed <= 1'b0;
      end else if (cntWrite) begin
         chkArmed <= 1'b1;
      end else if (tick) begin
         chkArmed <= 1'b0;
      end
   end

   // Bus, register, counting and force checks.
   a_ack_single: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      wbReq |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single cycle after request");
   a_res_bit_zero: assert property (  // [RULE_02]
      @(posedge clk_sys) disable iff (!rst_n)
      ctrlB[B_RES_BIT] == 1'b0)
      else $error("control B bit 5 not zero");
   a_ctrl_c_zero: assert property (  // [RULE_11]
      @(posedge clk_sys) disable iff (!rst_n)
      rdEn && idx == IDX_CTRL_C |=> wb_dat_o == 32'h0000_0000)
      else $error("control C read not zero");
   a_block_next_tick: assert property (  // [RULE_16]
      @(posedge clk_sys) disable iff (!rst_n)
      chkArmed && tick |=> matchEvent == 3'h0)
      else $error("compare not blocked after counter write");
   a_stop_frozen: assert property (  // [RULE_21]
      @(posedge clk_sys) disable iff (!rst_n)
      tickSel == T_STOP && !cntWrite |=> count == $past(count))
      else $error("counter moved while stopped");
   a_step_up: assert property (  // [RULE_21]
      @(posedge clk_sys) disable iff (!rst_n)
      tick && !cntWrite && !dual && !atTop |=> count == $past(count) + ONE16)
      else $error("counter did not step by one");
   a_pwm_no_force: assert property (  // [RULE_08]
      @(posedge clk_sys) disable iff (!rst_n)
      wrEn && idx == IDX_CTRL_C && isPwm(waveMode) |=> forcedMatch == 3'h0)
      else $error("force acted in a PWM mode");
   a_force_pass: assert property (  // [RULE_08]
      @(posedge clk_sys) disable iff (!rst_n)
      forceWr && wrByte[C_FORCE_A] |=> forcedMatch[0] && matchEvent == 3'h0
                                        || $past(hit) != 3'h0)
      else $error("forced match A missing or raised an event");
   a_force_no_clr: assert property (  // [RULE_09]
      @(posedge clk_sys) disable iff (!rst_n)
      forceWr && !tick |=> count == $past(count))
      else $error("forced match changed the counter");
   a_word_commit: assert property (  // [RULE_20]
      @(posedge clk_sys) disable iff (!rst_n)
      cntWrite |=> count == {$past(temp), $past(wrByte)})
      else $error("counter write not committed with temp");
   a_div8_tap: assert property (  // [RULE_06]
      @(posedge clk_sys) disable iff (!rst_n)
      tickSel == T_DIV8 && tick |-> (prescale & P_MASK8) == P_MASK8
                                    ##1 (!tick || tickSel != T_DIV8))
      else $error("divide by eight tick misplaced");

   // Further guards on the bus, control B, the byte pairing, the count sequence, the taps and the force strobes.
   a_ack_idle: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      !wbReq |=> !wb_ack_o)
      else $error("ack without a request");
   a_ctrl_b_keep: assert property (  // [RULE_01]
      @(posedge clk_sys) disable iff (!rst_n)
      wrEn && idx == IDX_CTRL_B |=> ctrlB == ($past(wrByte) & B_WR_MASK))
      else $error("control B write not stored");
   a_hi_read_temp: assert property (  // [RULE_14]
      @(posedge clk_sys) disable iff (!rst_n)
      rdEn && hiRead |=> wb_dat_o[7:0] == $past(temp))
      else $error("high byte read not from temp");
   a_hi_write_temp: assert property (  // [RULE_20]
      @(posedge clk_sys) disable iff (!rst_n)
      hiWrite |=> temp == $past(wrByte))
      else $error("high byte write not parked in temp");
   a_lo_read_latch: assert property (  // [RULE_20]
      @(posedge clk_sys) disable iff (!rst_n)
      loRead && idx == IDX_CNT_L |=> temp == 8'($past(count) >> 8))
      else $error("low byte read did not latch high byte");
   a_cmp_commit: assert property (  // [RULE_14]
      @(posedge clk_sys) disable iff (!rst_n)
      wrEn && idx == IDX_CMP_L
      |=> cmpVal[0] == {$past(temp), $past(wrByte)})
      else $error("compare A write not committed with temp");
   a_count_port: assert property (  // [RULE_13]
      @(posedge clk_sys) disable iff (!rst_n)
      countValue == count)
      else $error("count port differs from counter");
   a_slope_wrap: assert property (  // [RULE_04]
      @(posedge clk_sys) disable iff (!rst_n)
      tick && !cntWrite && !dual && atTop |=> count == RST_WORD)
      else $error("single slope did not wrap at top");
   a_ctc_clear: assert property (  // [RULE_04]
      @(posedge clk_sys) disable iff (!rst_n)
      waveMode == M_CTC_A && tick && !cntWrite && count == cmpVal[0]
      |=> count == RST_WORD)
      else $error("clear on match did not clear");
   a_dual_turn: assert property (  // [RULE_04] [RULE_05]
      @(posedge clk_sys) disable iff (!rst_n)
      tick && !cntWrite && dual && !countDown && atTop && top != RST_WORD
      |=> countDown)
      else $error("dual slope did not turn at top");
   a_dual_down: assert property (  // [RULE_05]
      @(posedge clk_sys) disable iff (!rst_n)
      tick && !cntWrite && dual && countDown && !atZero
      |=> count == $past(count) - ONE16)
      else $error("dual slope did not step down");
   a_div1024_tap: assert property (  // [RULE_06]
      @(posedge clk_sys) disable iff (!rst_n)
      tickSel == T_DIV1024 && tick |-> prescale == P_MASK1024)
      else $error("divide by 1024 tick misplaced");
   a_bad_sel_idle: assert property (  // [RULE_06]
      @(posedge clk_sys) disable iff (!rst_n)
      tickSel > T_DIV1024 |-> !tick)
      else $error("reserved tick select ticked");
   a_force_idle: assert property (  // [RULE_11]
      @(posedge clk_sys) disable iff (!rst_n)
      !forceWr |=> forcedMatch == 3'h0)
      else $error("forced match without a strobe");

endmodule

//--- test/tb.sv
`timescale 1ns/1ps
module tb
   import itc_pkg::*;
;
   logic        clk_sys;
   logic        rst_n;
   logic        wbCyc;
   logic        wbStb;
   logic        wbWe;
   logic [11:0] wbAdr;
   logic [3:0]  wbSel;
   logic [31:0] wbDatI;
   logic [31:0] wbDatO;
   logic        wbAck;
   logic [15:0] countValue;
   logic [2:0]  matchEvent;
   logic [2:0]  forcedMatch;
   logic [15:0] maxCnt;
   logic [2:0]  fmSeen;
   logic [2:0]  meSeen;
   int          fmCnt;
   int          meCnt;
   int          err_total;
   int          check_count;
   int          cycles;

   itc_timer u_itc_timer (.clk_sys(clk_sys), .rst_n(rst_n),
      .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
      .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
      .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .countValue(countValue),
      .matchEvent(matchEvent), .forcedMatch(forcedMatch));

   // The clock runs at 20 MHz.
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // Pulses are counted at the edge, so a one-cycle pulse counts once.
   always @(posedge clk_sys) begin
      cycles++;
      if (forcedMatch !== 3'b000) fmCnt++;
      fmSeen |= forcedMatch;
      if (matchEvent !== 3'b000) meCnt++;
      meSeen |= matchEvent;
      if (countValue > maxCnt) maxCnt = countValue;
      if (cycles == 20000) begin
         err_total++;
         $display("wrong value timeout expected 0 seen %0d", cycles);
         test_done();
      end
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [15:0] e,
                      input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   // Clearing waits 1 ns so it never races the counting process.
   task automatic clrEv();
      #1;
      fmCnt = 0;
      fmSeen = 3'b000;
      meCnt = 0;
      meSeen = 3'b000;
      maxCnt = 16'h0000;
   endtask

   // One classic cycle; the request stands until ack is sampled high.
   task automatic busXfer(input logic we, input logic [9:0] idx,
                          input logic [7:0] wd, output logic [7:0] rd);
      int n;
      n = 0;
      @(posedge clk_sys);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= {idx, 2'b00};
      wbDatI <= {24'h000000, wd};
      do begin
         @(posedge clk_sys);
         n++;
      end while (wbAck !== 1'b1 && n < 20);
      chk("ack", 16'h0001, {15'h0000, wbAck});
      rd = wbDatO[7:0];
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
   endtask

   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      logic [7:0] x;
      busXfer(1'b1, idx, d, x);
   endtask

   task automatic rdChk(input string n, input logic [9:0] idx,
                        input logic [7:0] e);
      logic [7:0] x;
      busXfer(1'b0, idx, 8'h00, x);
      chk(n, {8'h00, e}, {8'h00, x});
   endtask

   // High byte first on writes, low byte first on reads.
   task automatic wrCnt(input logic [15:0] v);
      wr(IDX_CNT_H, v[15:8]);
      wr(IDX_CNT_L, v[7:0]);
   endtask

   task automatic rdCnt(output logic [15:0] v);
      logic [7:0] lo;
      logic [7:0] hi;
      busXfer(1'b0, IDX_CNT_L, 8'h00, lo);
      busXfer(1'b0, IDX_CNT_H, 8'h00, hi);
      v = {hi, lo};
   endtask

   task automatic setMode(input logic [3:0] m, input logic [2:0] t);
      wr(IDX_CTRL_A, {6'h00, m[1:0]});
      wr(IDX_CTRL_B, {3'h0, m[3:2], t});
   endtask

   function automatic int divOf(input logic [2:0] t);
      case (t)
         T_DIV1: return 1;
         T_DIV8: return 8;
         T_DIV64: return 64;
         T_DIV256: return 256;
         T_DIV1024: return 1024;
         default: return 0;
      endcase
   endfunction

   function automatic logic nonPwm(input logic [3:0] m);
      return m == M_NORMAL || m == M_CTC_A || m == M_CTC_A2 || m == M_RSVD;
   endfunction

   // Main sequence.
   initial begin
      logic [15:0] w;
      logic [15:0] v;
      logic [7:0]  r;
      logic [3:0]  m;
      int          d;
      logic [15:0] e;
      rst_n = 1'b0;
      wbCyc = 1'b0;
      wbStb = 1'b0;
      wbWe = 1'b0;
      wbAdr = 12'h000;
      wbSel = 4'h1;
      wbDatI = 32'h00000000;
      void'($urandom(25514));
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      rdChk("ctrl_b reset", IDX_CTRL_B, RST_BYTE);
      rdChk("cmp_a_high reset", IDX_CMP_H, RST_BYTE);
      r = 8'($urandom) | 8'h20;
      wr(IDX_CTRL_B, r);
      rdChk("ctrl_b", IDX_CTRL_B, r & B_WR_MASK);
      wr(IDX_CTRL_C, 8'hff);
      rdChk("ctrl_c", IDX_CTRL_C, 8'h00);
      wr(10'h123, 8'h5a);
      rdChk("unmapped", 10'h123, 8'h00);
      $display("test registers done");
      setMode(M_NORMAL, T_STOP);
      w = 16'($urandom);
      wrCnt(w);
      rdCnt(v);
      chk("counter word", w, v);
      chk("count port", w, countValue);
      r = 8'($urandom);
      wr(IDX_CMP_H, r);
      wr(IDX_CNT_L, w[7:0]);
      rdCnt(v);
      chk("shared temp", {r, w[7:0]}, v);
      $display("test pairing done");
      for (int t = 0; t < 8; t++) begin
         d = divOf(3'(t));
         setMode(M_NORMAL, T_STOP);
         wrCnt(16'h0000);
         wr(IDX_CTRL_B, {5'h00, 3'(t)});
         @(posedge clk_sys);
         #1;
         w = countValue;
         repeat (2 * ((d > 0) ? d : 8)) @(posedge clk_sys);
         #1;
         chk("tick delta", (d > 0) ? 16'h0002 : 16'h0000,
             countValue - w);
      end
      $display("test tick rates done");
      setMode(M_NORMAL, T_STOP);
      r = 8'h10 + 8'($urandom_range(63, 0));
      wr(IDX_CMP_H, 8'h00);
      wr(IDX_CMP_L, r);
      wr(IDX_CMP_L + 10'h002, r);
      wr(IDX_CMP_L + 10'h004, r);
      wrCnt({8'h00, r - 8'h04});
      wr(IDX_CTRL_B, {5'h00, T_DIV1});
      clrEv();
      repeat (20) @(posedge clk_sys);
      #1;
      chk("match count", 16'h0001, 16'(meCnt));
      chk("match lanes", 16'h0007, {13'h0000, meSeen});
      wr(IDX_CTRL_B, {5'h00, T_STOP});
      wrCnt({8'h00, r});
      wr(IDX_CTRL_B, {5'h00, T_DIV1});
      clrEv();
      repeat (20) @(posedge clk_sys);
      #1;
      chk("blocked match", 16'h0000, 16'(meCnt));
      $display("test compare done");
      wr(IDX_CTRL_B, {5'h00, T_STOP});
      #1;
      w = countValue;
      for (int i = 0; i < 16; i++) begin
         m = 4'(i);
         setMode(m, T_STOP);
         clrEv();
         wr(IDX_CTRL_C, 8'he0);
         repeat (3) @(posedge clk_sys);
         #1;
         chk("forced", nonPwm(m) ? 16'h0017 : 16'h0000,
             {8'h00, 4'(fmCnt), 1'b0, fmSeen});
         chk("forced event", 16'h0000, 16'(meCnt));
         chk("forced count", w, countValue);
      end
      $display("test force done");
      for (int i = 0; i < 6; i++) begin
         m = (i == 0) ? M_CTC_A : (i == 1) ? M_FAST8 :
             (i == 2) ? M_CTC_A2 : (i == 3) ? M_FAST_A :
             (i == 4) ? M_PC8 : M_PFC_A;
         // After 41 ticks from 0x00f0 single slopes have wrapped once,
         // while dual slopes have turned at top and are falling.
         e = (m == M_FAST8) ? 16'h0019 : (m == M_PC8) ? 16'h00e5 :
             (m == M_PFC_A) ? 16'h00d7 : 16'h0020;
         setMode(m, T_STOP);
         wr(IDX_CMP_H, 8'h00);
         wr(IDX_CMP_L, 8'hf8);
         wrCnt(16'h00f0);
         wr(IDX_CTRL_B, {3'h0, m[3:2], T_DIV1});
         clrEv();
         repeat (40) @(posedge clk_sys);
         #1;
         chk("top value", (m == M_FAST8 || m == M_PC8) ? TOP8 : 16'h00f8,
             maxCnt);
         chk("end value", e, countValue);
      end
      $display("test modes done");
      test_done();
   end
endmodule
